// file: core/dsp_pkg.sv
// Constants shared by the two-word-burst DDR SRAM port model.
// Assumes one system clock far faster than the sampled link clocks.
package dsp_pkg;
    // Widest external address, in words of two-word locations.
    localparam int ADDR_W = 21;
    // Widest data word; narrower variants use the low bits.
    localparam int DATA_MAX_W = 36;
    // Narrowest width that still takes the burst start from the address.
    localparam int WIDE_MIN_W = 18;
    // Word-index bits of the storage array held in this model.
    localparam int MEM_IDX_W = 10;
    // Launch half-edges from read capture to the first word, loop on.
    localparam logic [2:0] RD_FIRST_DLL_ON = 3'h3;
    // Launch half-edges from read capture to the first word, loop off.
    localparam logic [2:0] RD_FIRST_DLL_OFF = 3'h2;
    // Reset value of the half-edge counter.
    localparam logic [2:0] RD_CNT_RESET = 3'h0;
    // Write burst sequencing states.
    typedef enum logic [1:0] {
        DSP_WR_IDLE = 2'b00,
        DSP_WR_BEAT0 = 2'b01,
        DSP_WR_BEAT1 = 2'b10
    } dsp_wr_state_t;
endpackage : dsp_pkg

// file: core/dsp_port.sv
// Synchronous port of a double-data-rate SRAM with a two-word burst.
// Assumes the link clocks are far slower than sys_clk_in and are sampled.
`timescale 1ns/1ps

// Contract
// - Addresses taken only every other K rise.
// - Write words taken on K and K-bar rises.
// - Reads launch on C pair, else K pair.
// - One-bit counter: two words per address.
// - Narrow widths start the burst at zero.
// - Wide widths start burst from address bit.
// - Each beat is one word of configured width.
// - Loop on: first read word after 1.5 cycles.
// - Loop off: read latency of one cycle.
// - Read data on shared pins with echo clocks.
// - All synchronous inputs registered before use.
// - Writes self-timed; no write pulse needed.
module dsp_port #(
    parameter int WORD_W = 36
) (
    // System clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Input clock pair and output clock pair from the host.
    input wire logic k_clk_in,
    input wire logic k_clk_n_in,
    input wire logic c_clk_in,
    input wire logic c_clk_n_in,
    // High when the output clock pair is supplied.
    input wire logic out_clocks_used_in,
    // High when the delay-locked loop is disabled.
    input wire logic dll_disable_in,
    // Burst control and address.
    input wire logic load_strobe_n_in,
    input wire logic read_not_write_in,
    input wire logic [dsp_pkg::ADDR_W-1:0] addr_in,
    // Shared data pins.
    input wire logic [WORD_W-1:0] dq_in,
    output logic [WORD_W-1:0] dq_out,
    output logic dq_oe_n_out,
    // Echo clock pair.
    output logic echo_clock_pair_out,
    output logic echo_clock_pair_n_out
);

    // Word index into the storage array for a location and burst beat.
    function automatic logic [dsp_pkg::MEM_IDX_W-1:0] word_index(
        input logic [dsp_pkg::ADDR_W-1:0] loc,
        input logic beat
    );
        logic [dsp_pkg::ADDR_W:0] full;
        full = (WORD_W >= dsp_pkg::WIDE_MIN_W) ? {1'b0, loc} : {loc, 1'b0};
        // The burst counter replaces the lowest index bit, so both burst orders share one word pair.
        word_index = {full[dsp_pkg::MEM_IDX_W-1:1], beat};
    endfunction : word_index

    // Idle levels of C-bar, C, K-bar and K, so that leaving reset shows no false edge.
    localparam logic [3:0] CLK_IDLE = 4'ha;
    // First synchroniser stage of every pin input except read select.
    logic [3:0] clk_meta;
    logic [2:0] lvl_meta;
    logic [dsp_pkg::ADDR_W-1:0] addr_meta;
    logic [WORD_W-1:0] dq_meta;
    // Second synchroniser stage, the first one logic may read.
    logic [3:0] clk_sync;
    logic [2:0] lvl_sync;
    logic [dsp_pkg::ADDR_W-1:0] addr_sync;
    logic [WORD_W-1:0] dq_sync;
    // Previous clock levels for edge finding.
    logic [3:0] clk_prev;
    // Rising-edge pulses of K, K-bar, C, C-bar.
    logic [3:0] clk_rise;
    // Launch edges for the read data path.
    logic launch_rise;
    logic launch_fall;
    logic launch_any;
    // Blocks the K rise that follows an accepted address.
    logic addr_blocked;
    // Accept pulses for the two burst kinds.
    logic accept;
    logic accept_read;
    logic accept_write;
    // Burst start beat of the accepted address.
    logic start_beat;
    // Storage array.
    logic [WORD_W-1:0] mem [0:(1<<dsp_pkg::MEM_IDX_W)-1];
    // Write burst state.
    dsp_pkg::dsp_wr_state_t wr_state;
    dsp_pkg::dsp_wr_state_t next_wr_state;
    logic [dsp_pkg::ADDR_W-1:0] wr_addr;
    logic wr_beat;
    // Read burst state.
    logic rd_pending;
    // High while the output pair has not yet shown its image of the capture edge.
    logic rd_skip;
    logic [2:0] rd_cnt;
    logic [2:0] next_rd_cnt;
    logic [2:0] rd_first;
    logic [WORD_W-1:0] rd_word0;
    logic [WORD_W-1:0] rd_word1;

    // Two flip-flops on every pin input before any logic reads it.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            clk_meta <= CLK_IDLE;
            lvl_meta <= 3'h1;
            addr_meta <= '0;
            dq_meta <= '0;
            clk_sync <= CLK_IDLE;
            lvl_sync <= 3'h1;
            addr_sync <= '0;
            dq_sync <= '0;
        end else begin
            clk_meta <= {c_clk_n_in, c_clk_in, k_clk_n_in, k_clk_in};
            lvl_meta <= {out_clocks_used_in, dll_disable_in, load_strobe_n_in};
            addr_meta <= addr_in;
            dq_meta <= dq_in;
            clk_sync <= clk_meta;
            lvl_sync <= lvl_meta;
            addr_sync <= addr_meta;
            dq_sync <= dq_meta;
        end
    end

    // Read select has a synchroniser pair of its own, apart from the control levels.
    logic rw_meta;
    logic rw_sync;

    // Synchronises the read select line.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rw_meta <= 1'b1;
            rw_sync <= 1'b1;
        end else begin
            rw_meta <= read_not_write_in;
            rw_sync <= rw_meta;
        end
    end

    // Keeps the last synchronised clock levels for edge detection.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            clk_prev <= CLK_IDLE;
        end else begin
            clk_prev <= clk_sync;
        end
    end

    // Edge finding and choice of launch clocks.
    always_comb begin
        clk_rise = clk_sync & ~clk_prev;
        // The output pair launches data when supplied, else the input pair.
        launch_rise = lvl_sync[2] ? clk_rise[2] : clk_rise[0];
        launch_fall = lvl_sync[2] ? clk_rise[3] : clk_rise[1];
        launch_any = launch_rise | launch_fall;
    end

    // Address acceptance on a K rise with load low, unless just used.
    always_comb begin
        accept = clk_rise[0] & ~lvl_sync[0] & ~addr_blocked;
        accept_read = accept & rw_sync;
        accept_write = accept & ~rw_sync;
        // Narrow parts always start at zero; wide parts take address bit 0.
        start_beat = (WORD_W >= dsp_pkg::WIDE_MIN_W) ? addr_sync[0] : 1'b0;
    end

    // A burst occupies two K cycles, so the next K rise is ignored.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            addr_blocked <= 1'b0;
        end else if (clk_rise[0]) begin
            addr_blocked <= accept;
        end
    end

    // Next write state: address, then a word on K, then one on K-bar.
    always_comb begin
        next_wr_state = wr_state;
        unique case (wr_state)
            dsp_pkg::DSP_WR_IDLE: begin
                // Waits for a write address.
                if (accept_write) begin
                    next_wr_state = dsp_pkg::DSP_WR_BEAT0;
                end
            end
            dsp_pkg::DSP_WR_BEAT0: begin
                // First word rides the following K rise.
                if (clk_rise[0]) begin
                    next_wr_state = dsp_pkg::DSP_WR_BEAT1;
                end
            end
            dsp_pkg::DSP_WR_BEAT1: begin
                // Second word rides the K-bar rise.
                if (clk_rise[1]) begin
                    next_wr_state = dsp_pkg::DSP_WR_IDLE;
                end
            end
            default: begin
                // Recovers from an illegal code.
                next_wr_state = dsp_pkg::DSP_WR_IDLE;
            end
        endcase
    end

    // Write sequencing register.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_state <= dsp_pkg::DSP_WR_IDLE;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    // Holds the write location and walks the one-bit burst counter.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_addr <= '0;
            wr_beat <= 1'b0;
        end else if (accept_write) begin
            wr_addr <= addr_sync;
            wr_beat <= start_beat;
        end else if (wr_state == dsp_pkg::DSP_WR_BEAT0 && clk_rise[0]) begin
            wr_beat <= ~wr_beat;
        end
    end

    // Self-timed store: each captured word lands with no host strobe.
    always_ff @(posedge sys_clk_in) begin
        if (wr_state == dsp_pkg::DSP_WR_BEAT0 && clk_rise[0]) begin
            mem[word_index(wr_addr, wr_beat)] <= dq_sync;
        end
        if (wr_state == dsp_pkg::DSP_WR_BEAT1 && clk_rise[1]) begin
            mem[word_index(wr_addr, wr_beat)] <= dq_sync;
        end
    end

    // Fetches both burst words at read capture, in counter order.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_word0 <= '0;
            rd_word1 <= '0;
        end else if (accept_read) begin
            rd_word0 <= mem[word_index(addr_sync, start_beat)];
            rd_word1 <= mem[word_index(addr_sync, ~start_beat)];
        end
    end

    // Loop mode picks how many launch half-edges precede the first word.
    always_comb begin
        rd_first = lvl_sync[1] ? dsp_pkg::RD_FIRST_DLL_OFF : dsp_pkg::RD_FIRST_DLL_ON;
        next_rd_cnt = rd_cnt + 3'h1;
    end

    // Counts launch half-edges of the read in flight.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_pending <= 1'b0;
            rd_skip <= 1'b0;
            rd_cnt <= dsp_pkg::RD_CNT_RESET;
        end else if (accept_read) begin
            rd_pending <= 1'b1;
            // A lagging C rise after capture is the capture edge itself, so it is not counted.
            rd_skip <= lvl_sync[2] & ~launch_rise;
            rd_cnt <= dsp_pkg::RD_CNT_RESET;
        end else if (rd_pending && rd_skip) begin
            // Waits for the output pair to catch up with the capture edge.
            if (launch_rise) begin
                rd_skip <= 1'b0;
            end
        end else if (rd_pending && launch_any) begin
            rd_cnt <= next_rd_cnt;
            if (next_rd_cnt == rd_first + 3'h1) begin
                rd_pending <= 1'b0;
            end
        end
    end

    // Output register: each launch edge drives a word or releases the pins.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            dq_out <= '0;
            dq_oe_n_out <= 1'b1;
        end else if (launch_any) begin
            if (rd_pending && next_rd_cnt == rd_first) begin
                dq_out <= rd_word0;
                dq_oe_n_out <= 1'b0;
            end else if (rd_pending && next_rd_cnt == rd_first + 3'h1) begin
                dq_out <= rd_word1;
                dq_oe_n_out <= 1'b0;
            end else begin
                dq_oe_n_out <= 1'b1;
            end
        end
    end

    // Echo clocks follow the launch edges so data and echo move together.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            echo_clock_pair_out <= 1'b0;
            echo_clock_pair_n_out <= 1'b1;
        end else if (launch_rise) begin
            echo_clock_pair_out <= 1'b1;
            echo_clock_pair_n_out <= 1'b0;
        end else if (launch_fall) begin
            echo_clock_pair_out <= 1'b0;
            echo_clock_pair_n_out <= 1'b1;
        end
    end

endmodule : dsp_port

// file: sim/dsp_port_asserts.sv
// Assertions on the read side of the burst SRAM port.
// Bound to every port instance; sees only its pins.
`timescale 1ns/1ps
module dsp_port_asserts #(
    parameter int WORD_W = 36
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Launch clocks and mode.
    input wire logic k_clk_in,
    input wire logic c_clk_in,
    input wire logic out_clocks_used_in,
    // Read side.
    input wire logic [WORD_W-1:0] dq_out,
    input wire logic dq_oe_n_out,
    input wire logic echo_clock_pair_out,
    input wire logic echo_clock_pair_n_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // Launch pin picked by the mode input.
    wire launch_clk = out_clocks_used_in ? c_clk_in : k_clk_in;
    // An output launch step.
    sequence echo_step; $changed(echo_clock_pair_out); endsequence
    // A launch pin edge three to six cycles back, the synchroniser delay.
    sequence pin_step; $past(launch_clk, 3) != $past(launch_clk, 6); endsequence
    echo_pair_a: assert property (echo_clock_pair_n_out == !echo_clock_pair_out) else $error("echo pair");
    echo_launch_a: assert property (echo_step |-> pin_step) else $error("echo off launch");
    echo_space_a: assert property (echo_step |=> $stable(echo_clock_pair_out) [*3]) else $error("echo gap");
    oe_start_a: assert property ($fell(dq_oe_n_out) |-> echo_step) else $error("drive off launch");
    oe_release_a: assert property ($rose(dq_oe_n_out) |-> echo_step) else $error("release off launch");
    oe_gap_a: assert property ($rose(dq_oe_n_out) |=> dq_oe_n_out [*3]) else $error("short release");
    dq_launch_a: assert property ($changed(dq_out) && !dq_oe_n_out |-> echo_step) else $error("word moved");
    burst_two_a: assert property ($fell(dq_oe_n_out) |-> !dq_oe_n_out [*8]) else $error("short burst");
endmodule : dsp_port_asserts

bind dsp_port dsp_port_asserts #(.WORD_W(WORD_W)) u_asserts (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .k_clk_in(k_clk_in), .c_clk_in(c_clk_in), .out_clocks_used_in(out_clocks_used_in), .dq_out(dq_out),
    .dq_oe_n_out(dq_oe_n_out), .echo_clock_pair_out(echo_clock_pair_out),
    .echo_clock_pair_n_out(echo_clock_pair_n_out));

// file: sim/dsp_host_model.sv
// Host memory controller model for the burst SRAM link.
// Assumes the port samples every link pin with its own clock.
`timescale 1ns/1ps
module dsp_host (
    // Input and output clock pairs.
    output logic k_out,
    output logic k_n_out,
    output logic c_out,
    output logic c_n_out,
    // Request and write data.
    output logic load_n_out,
    output logic rnw_out,
    output logic [dsp_pkg::ADDR_W-1:0] addr_out,
    output logic [35:0] wdata_out
);
    // Time of the last capturing K rise.
    realtime t_acc;
    assign k_n_out = ~k_out;
    assign c_n_out = ~c_out;
    // K runs free once started, in a phase unrelated to the system clock.
    initial begin
        k_out = 1'b0;
        load_n_out = 1'b1;
        rnw_out = 1'b1;
        addr_out = '0;
        wdata_out = '0;
        #1137;
        forever #400 k_out = ~k_out;
    end
    // The output pair trails K by a quarter period.
    assign #200 c_out = k_out;
    // One request; held is how many K rises see the strobe low.
    task automatic req(input logic rw, input logic [dsp_pkg::ADDR_W-1:0] a, input int held);
        @(negedge k_out);
        load_n_out = 1'b0;
        rnw_out = rw;
        addr_out = a;
        @(posedge k_out);
        t_acc = $realtime;
        repeat (held - 1) @(posedge k_out);
        @(negedge k_out);
        load_n_out = 1'b1;
    endtask : req
    // Word0 meets the next K rise, word1 the K-bar rise after; then the data lines carry the inverse of word1.
    task automatic wr(input logic [dsp_pkg::ADDR_W-1:0] a, input logic [35:0] w0, w1);
        req(1'b0, a, 1);
        wdata_out = w0;
        @(posedge k_out);
        #200 wdata_out = w1;
        @(negedge k_out);
        #200 wdata_out = ~w1;
    endtask : wr
endmodule : dsp_host

// file: sim/test_ddr_two_word_burst_sram_port.sv
// Testbench for the burst SRAM port, a wide and a narrow instance side by side.
// Assumes the host model drives the link and the checker is bound.
`timescale 1ns/1ps
module test_ddr_two_word_burst_sram_port;
    // Clock, reset and mode pins.
    logic sys_clk_in, reset_in, dll_off, out_sel;
    // Link wires and both ports' read sides.
    wire k, k_n, c, c_n, ld_n, rnw, woe, noe, wecho;
    wire [dsp_pkg::ADDR_W-1:0] addr;
    wire [35:0] hdq, wq, dq_w;
    wire [7:0] nq, dq_n;
    // Result counters.
    int n_errors, comparisons;
    // Shared pins carry whichever side drives them.
    assign dq_w = !woe ? wq : hdq;
    assign dq_n = !noe ? nq : hdq[7:0];
    dsp_host host (.k_out(k), .k_n_out(k_n), .c_out(c), .c_n_out(c_n), .load_n_out(ld_n), .rnw_out(rnw),
        .addr_out(addr), .wdata_out(hdq));
    dsp_port #(.WORD_W(36)) DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .k_clk_in(k), .k_clk_n_in(k_n),
        .c_clk_in(c), .c_clk_n_in(c_n), .out_clocks_used_in(out_sel), .dll_disable_in(dll_off),
        .load_strobe_n_in(ld_n), .read_not_write_in(rnw), .addr_in(addr), .dq_in(dq_w), .dq_out(wq),
        .dq_oe_n_out(woe), .echo_clock_pair_out(wecho), .echo_clock_pair_n_out());
    dsp_port #(.WORD_W(8)) DUT8 (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .k_clk_in(k), .k_clk_n_in(k_n),
        .c_clk_in(c), .c_clk_n_in(c_n), .out_clocks_used_in(out_sel), .dll_disable_in(dll_off),
        .load_strobe_n_in(ld_n), .read_not_write_in(rnw), .addr_in(addr), .dq_in(dq_n), .dq_out(nq),
        .dq_oe_n_out(noe), .echo_clock_pair_out(), .echo_clock_pair_n_out());
    // System clock, 100 ns period.
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Compares one value and counts it.
    task automatic chk(input logic [35:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Waits a bounded number of cycles for the echo to move.
    task automatic next_edge();
        logic ec;
        ec = wecho;
        for (int n = 0; n < 8 && wecho === ec; n++) begin
            @(posedge sys_clk_in);
            #5;
        end
    endtask : next_edge
    // Takes one burst from both ports; each word shows three system clock edges, about 218 ns, after its launch edge.
    task automatic burst(input logic [35:0] w0, w1, input logic [7:0] n0, n1, input int lat);
        realtime d;
        for (int n = 0; n < 40 && woe !== 1'b0; n++) begin
            @(posedge sys_clk_in);
            #5;
        end
        d = $realtime - host.t_acc - lat * 400 - (out_sel ? 200 : 0);
        chk({35'h0, d >= 200 && d <= 310}, 36'h1);
        chk({34'h0, woe, noe}, 36'h0);
        chk(wq, w0);
        chk({28'h0, nq}, {28'h0, n0});
        next_edge();
        chk(wq, w1);
        chk({28'h0, nq}, {28'h0, n1});
        next_edge();
        chk({34'h0, woe, noe}, 36'h3);
    endtask : burst
    // Resets into a new mode, releasing while both clock pairs are low.
    task automatic set_mode(input logic dll, sel);
        @(posedge sys_clk_in);
        #5 reset_in = 1'b1;
        dll_off = dll;
        out_sel = sel;
        repeat (5) @(posedge sys_clk_in);
        chk({34'h0, woe, wecho}, 36'h2);
        @(negedge k);
        #200;
        @(posedge sys_clk_in);
        #5 reset_in = 1'b0;
    endtask : set_mode
    // Wide words follow the address bit and share a location pair; narrow ones always start at zero.
    task automatic t_order();
        host.wr(21'h000025, 36'h1a2b3c4d5, 36'h2b3c4d5e6);
        host.wr(21'h000024, 36'h3c4d5e6f7, 36'h4d5e6f708);
        host.req(1'b1, 21'h000025, 1);
        burst(36'h4d5e6f708, 36'h3c4d5e6f7, 8'hd5, 8'he6, 2);
        host.req(1'b1, 21'h000024, 1);
        burst(36'h3c4d5e6f7, 36'h4d5e6f708, 8'hf7, 8'h08, 2);
    endtask : t_order
    // Loop on and output pair: first word half a cycle later, at the top location.
    task automatic t_loop_on();
        set_mode(1'b0, 1'b1);
        host.wr(21'h0003ff, 36'h5e6f70819, 36'h6f708192a);
        host.req(1'b1, 21'h0003ff, 1);
        burst(36'h5e6f70819, 36'h6f708192a, 8'h19, 8'h2a, 3);
    endtask : t_loop_on
    // A strobe held over two K rises starts a single burst.
    task automatic t_refuse();
        set_mode(1'b1, 1'b1);
        host.wr(21'h000010, 36'h708192a3b, 36'h8192a3b4c);
        host.req(1'b1, 21'h000010, 2);
        burst(36'h708192a3b, 36'h8192a3b4c, 8'h3b, 8'h4c, 2);
    endtask : t_refuse
    // Main sequence.
    initial begin
        n_errors = 0;
        comparisons = 0;
        reset_in = 1'b1;
        dll_off = 1'b1;
        out_sel = 1'b0;
        repeat (5) @(posedge sys_clk_in);
        #5 reset_in = 1'b0;
        t_order();
        t_loop_on();
        t_refuse();
        end_sim();
    end
    // Cuts a hang short well past the expected run of about 25 us.
    initial begin
        #200000;
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        end_sim();
    end
endmodule : test_ddr_two_word_burst_sram_port
